/* mdu_top.v */
`timescale 1ns/1ps
`include "mdu_defines.vh"
// Summary of operation
// - multiply 16 by 16 into 32-bit product
// - divide 32 by 16, quotient and remainder
// - remainder holds remainder, zero after multiply
// - remainder readable 8/16 bit, reset zero
// - reads during operation may show intermediates
// - remainder cleared when start is set
// - operand A split halves, result in place
// - multiply launch clears operand A high half
// - multiply uses low half; quotient replaces dividend
// - intermediate results loaded from next clock
// - operand A halves writable 8/16 bit, reset zero
// - operand B holds multiplicand/divisor, reset zero
// - control resets zero: stopped, division mode
// - start bit launches, self-clears on the edge that raises interrupt
// - bit 0 selects multiply (1) or divide (0)
// - multiply 16 clocks, divide 32 clocks
// - clearing start aborts operation
module mdu_top (
  clk_sys,
  resetn,
  addr,
  wr_en,
  byte_en,
  wdata,
  rdata,
  muldiv_done_irq
);
  input wire clk_sys;
  input wire resetn;
  input wire [2:0] addr;
  input wire wr_en;
  input wire [1:0] byte_en;
  input wire [15:0] wdata;
  output reg [15:0] rdata;
  output reg muldiv_done_irq;

  reg [15:0] remainder_result_r;
  reg [15:0] operand_a_result_high_r;
  reg [15:0] operand_a_result_low_r;
  reg [15:0] operand_b_divisor_r;
  reg op_start_active_r;
  reg mul_not_div_select_r;
  reg [5:0] count_r;
  reg [16:0] acc_r;
  wire [16:0] acc_out;
  wire [31:0] quo_out;
  wire [31:0] operand_a_result;
  wire wr_ctrl;
  wire launch;
  wire last_step;
  wire [15:0] ctrl_merge;
  wire abort;
  wire iterate;
  wire run_done;
  wire host_wr;

  assign operand_a_result = {operand_a_result_high_r, operand_a_result_low_r};
  assign wr_ctrl = wr_en && addr == `MDU_SEL_CTRL && byte_en[0];
  assign ctrl_merge = {8'h00, wdata[7:0]};
  assign launch = wr_ctrl && ctrl_merge[`MDU_CTRL_START_BIT] &&
    !op_start_active_r;
  assign last_step = op_start_active_r &&
    count_r == (mul_not_div_select_r ? `MDU_MUL_CYCLES - 6'h01 :
    `MDU_DIV_CYCLES - 6'h01);
  // a control write with start low stops a run at once
  assign abort = wr_ctrl && !ctrl_merge[`MDU_CTRL_START_BIT];
  assign iterate = op_start_active_r && !abort;
  assign run_done = iterate && last_step;
  assign host_wr = wr_en && !op_start_active_r;

  // unsigned datapath: acc is remainder/upper product
  mdu_step u_step (
    .mul_mode(mul_not_div_select_r),
    .acc(acc_r),
    .quo(operand_a_result),
    .operand_b(operand_b_divisor_r),
    .acc_out(acc_out),
    .quo_out(quo_out)
  );

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      op_start_active_r <= 1'b0;
      mul_not_div_select_r <= 1'b0;
    end
    else
    begin
      // mode bit follows writes; changing it mid-run is undefined
      if (wr_ctrl)
        mul_not_div_select_r <= ctrl_merge[`MDU_CTRL_MUL_BIT];
      if (launch)
        op_start_active_r <= 1'b1;
      else if (abort)
        op_start_active_r <= 1'b0; // abort, result not kept
      else if (run_done)
        op_start_active_r <= 1'b0; // start clears itself
    end
  end

  // one-cycle completion pulse, set after the last step
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      muldiv_done_irq <= 1'b0;
    else
      muldiv_done_irq <= run_done;
  end

  // acc carries the partial remainder or the upper product
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= 6'h00;
      acc_r <= 17'h00000;
    end
    else if (launch)
    begin
      count_r <= 6'h00;
      acc_r <= 17'h00000;
    end
    else if (iterate)
    begin
      count_r <= count_r + 6'h01;
      acc_r <= acc_out;
    end
  end

  // remainder shows the partial remainder while dividing
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      remainder_result_r <= `MDU_REG16_RST;
    else if (launch)
      remainder_result_r <= `MDU_REG16_RST;
    else if (iterate)
    begin
      if (mul_not_div_select_r)
        remainder_result_r <= 16'h0000;
      else
        remainder_result_r <= acc_out[15:0];
    end
  end

  // result register takes partial results every clock
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      operand_a_result_high_r <= `MDU_REG16_RST;
      operand_a_result_low_r <= `MDU_REG16_RST;
    end
    else if (launch)
    begin
      if (ctrl_merge[`MDU_CTRL_MUL_BIT])
        operand_a_result_high_r <= 16'h0000;
    end
    else if (run_done && mul_not_div_select_r)
    begin
      // product overwrites all 32 bits
      operand_a_result_high_r <= acc_out[15:0];
      operand_a_result_low_r <= quo_out[15:0];
    end
    else if (iterate)
    begin
      operand_a_result_high_r <= quo_out[31:16];
      operand_a_result_low_r <= quo_out[15:0];
    end
    else if (host_wr && addr == `MDU_SEL_A_LOW)
    begin
      // byte lanes give the 8-bit access form
      if (byte_en[0]) operand_a_result_low_r[7:0] <= wdata[7:0];
      if (byte_en[1]) operand_a_result_low_r[15:8] <= wdata[15:8];
    end
    else if (host_wr && addr == `MDU_SEL_A_HIGH)
    begin
      if (byte_en[0]) operand_a_result_high_r[7:0] <= wdata[7:0];
      if (byte_en[1]) operand_a_result_high_r[15:8] <= wdata[15:8];
    end
  end

  // writes while running are dropped; the run keeps its divisor
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      operand_b_divisor_r <= `MDU_REG16_RST;
    else if (host_wr && addr == `MDU_SEL_B)
    begin
      if (byte_en[0]) operand_b_divisor_r[7:0] <= wdata[7:0];
      if (byte_en[1]) operand_b_divisor_r[15:8] <= wdata[15:8];
    end
  end

  // registered read data; full 16 bits, host picks its byte
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata <= 16'h0000;
    else
    begin
      case (addr)
        `MDU_SEL_REM: rdata <= remainder_result_r;
        `MDU_SEL_A_LOW: rdata <= operand_a_result_low_r;
        `MDU_SEL_A_HIGH: rdata <= operand_a_result_high_r;
        `MDU_SEL_B: rdata <= operand_b_divisor_r;
        `MDU_SEL_CTRL: rdata <= {8'h00, op_start_active_r, 6'h00,
          mul_not_div_select_r};
        default: rdata <= 16'h0000;
      endcase
    end
  end
endmodule // mdu_top

/* mdu_defines.vh */
`ifndef MDU_DEFINES_VH
`define MDU_DEFINES_VH
// register selects (addr port, one code per 16-bit register)
`define MDU_SEL_REM 3'h0
`define MDU_SEL_A_LOW 3'h1
`define MDU_SEL_A_HIGH 3'h2
`define MDU_SEL_B 3'h3
`define MDU_SEL_CTRL 3'h4
// control register fields
`define MDU_CTRL_START_BIT 7
`define MDU_CTRL_MUL_BIT 0
`define MDU_CTRL_RST 8'h00
`define MDU_REG16_RST 16'h0000
// cycles per operation
`define MDU_MUL_CYCLES 6'h10
`define MDU_DIV_CYCLES 6'h20
`endif

/* mdu_step.v */
`timescale 1ns/1ps
// one iteration of the shift-add multiplier or restoring divider
module mdu_step (
  mul_mode,
  acc,
  quo,
  operand_b,
  acc_out,
  quo_out
);
  input wire mul_mode;
  input wire [16:0] acc;
  input wire [31:0] quo;
  input wire [15:0] operand_b;
  output reg [16:0] acc_out;
  output reg [31:0] quo_out;
  reg [17:0] sum;
  reg [16:0] trial;
  always @*
  begin
    sum = 18'h00000;
    trial = 17'h00000;
    acc_out = acc;
    quo_out = quo;
    if (mul_mode)
    begin
      // acc holds upper product bits, quo low holds multiplier
      sum = {1'b0, acc} + (quo[0] ? {2'b00, operand_b} : 18'h00000);
      acc_out = sum[17:1];
      quo_out = {16'h0000, sum[0], quo[15:1]};
    end
    else
    begin
      trial = {acc[15:0], quo[31]};
      if (trial >= {1'b0, operand_b})
      begin
        acc_out = trial - {1'b0, operand_b};
        quo_out = {quo[30:0], 1'b1};
      end
      else
      begin
        acc_out = trial;
        quo_out = {quo[30:0], 1'b0};
      end
    end
  end
endmodule // mdu_step

/* mdu_top_sva.sv */
`timescale 1ns/1ps
module mdu_top_sva (
  input wire clk_sys,
  input wire resetn,
  input wire [2:0] addr,
  input wire wr_en,
  input wire [1:0] byte_en,
  input wire [15:0] wdata,
  input wire [15:0] rdata,
  input wire muldiv_done_irq
);
  wire cw = wr_en && addr == 3'h4 && byte_en[0];
  wire go_m = cw && wdata[7] && wdata[0];
  wire go_d = cw && wdata[7] && !wdata[0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_irq_one_cycle: assert property (
    muldiv_done_irq |=> !muldiv_done_irq)
    else $error("done pulse longer than one cycle");
  a_mul_latency: assert property (go_m ##1 !wr_en[*8]
    ##1 !wr_en[*8] |=> muldiv_done_irq)
    else $error("multiply not done in 16 clocks");
  a_div_latency: assert property (go_d ##1 !wr_en[*8]
    ##1 !wr_en[*8] ##1 !wr_en[*8] ##1 !wr_en[*8] |=> muldiv_done_irq)
    else $error("divide not done in 32 clocks");
  a_rem_cleared: assert property (go_d ##1 addr == 3'h0
    |=> rdata == 16'h0) else $error("remainder not cleared at start");
  a_high_cleared: assert property (go_m ##1 addr == 3'h2
    |=> rdata == 16'h0) else $error("upper operand half not cleared");
  a_abort_no_irq: assert property (cw && !wdata[7]
    |=> !muldiv_done_irq[*8]) else $error("done pulse after abort");
  a_abort_quiet: assert property (cw && !wdata[7]
    ##1 !wr_en[*8] ##1 !wr_en[*8] ##1 !wr_en[*8] ##1 !wr_en[*8]
    |-> !muldiv_done_irq) else $error("aborted run still completed");
  a_start_self_clr: assert property (muldiv_done_irq
    && addr == 3'h4 |=> !rdata[7])
    else $error("start bit still set after done");
  a_unmapped_zero: assert property (addr > 3'h4 |=> rdata == 16'h0)
    else $error("unmapped select reads nonzero");
endmodule // mdu_top_sva
bind mdu_top mdu_top_sva u_sva (.clk_sys(clk_sys), .resetn(resetn),
  .addr(addr), .wr_en(wr_en), .byte_en(byte_en), .wdata(wdata),
  .rdata(rdata), .muldiv_done_irq(muldiv_done_irq));

/* mdu_cpu_model.sv */
`timescale 1ns/1ps
module mdu_cpu_model (
  input wire clk_sys,
  input wire [15:0] rdata,
  output logic [2:0] addr,
  output logic wr_en,
  output logic [1:0] byte_en,
  output logic [15:0] wdata
);
  initial {addr, wr_en, byte_en, wdata} = 22'h0;
  // strobe stays up between writes so back-to-back writes never glitch it
  task wr(input [2:0] a, input [1:0] be, input [15:0] d);
    addr = a;
    byte_en = be;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
  task rd(input [2:0] a, output [15:0] d);
    addr = a;
    wr_en = 1'b0;
    wdata = ~wdata; // a released data bus does not keep its last value
    @(posedge clk_sys);
    #1 d = rdata;
  endtask
endmodule // mdu_cpu_model

/* tb_mul_div_unit.sv */
`timescale 1ns/1ps
module tb_mul_div_unit;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  wire [2:0] addr;
  wire wr_en;
  wire [1:0] byte_en;
  wire [15:0] wdata;
  wire [15:0] rdata;
  wire muldiv_done_irq;
  int failures = 0;
  int comparisons = 0;
  int n;
  logic [15:0] d;
  logic [15:0] b;
  logic [15:0] r;
  logic [31:0] a;
  logic [31:0] q;
  initial forever #20 clk_sys = ~clk_sys;
  mdu_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
    .wr_en(wr_en), .byte_en(byte_en), .wdata(wdata), .rdata(rdata),
    .muldiv_done_irq(muldiv_done_irq));
  mdu_cpu_model u_cpu (.clk_sys(clk_sys), .rdata(rdata), .addr(addr),
    .wr_en(wr_en), .byte_en(byte_en), .wdata(wdata));
  task check(input [15:0] got, input [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rc(input [2:0] sel, input [15:0] exp);
    u_cpu.rd(sel, d);
    check(d, exp);
  endtask
  task end_of_test;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    failures++;
    end_of_test;
  end
  initial
  begin
    n = $urandom(32'h5d3d9dcb);
    repeat (10) @(posedge clk_sys);
    #1 resetn = 1'b1;
    for (int i = 0; i < 8; i++)
      rc(i[2:0], 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      a = $urandom;
      // operands are only written while the unit is idle
      b = 16'($urandom) | 16'h0001;
      u_cpu.wr(3'h1, 2'b11, ~a[15:0]);
      u_cpu.wr(3'h1, 2'b01, {~a[15:8], a[7:0]});
      u_cpu.wr(3'h1, 2'b10, {a[15:8], ~a[7:0]});
      u_cpu.wr(3'h2, 2'b11, a[31:16]);
      u_cpu.wr(3'h3, 2'b11, b);
      rc(3'h3, b);
      u_cpu.wr(3'h4, 2'b01, {15'h0040, i[0]});
      rc(i[0] ? 3'h2 : 3'h0, 16'h0000);
      n = 1;
      while (muldiv_done_irq !== 1'b1 && n < 40)
      begin
        u_cpu.rd(3'h4, d);
        n++;
      end
      check(n[15:0], i[0] ? 16'd16 : 16'd32);
      rc(3'h4, {15'h0000, i[0]});
      q = i[0] ? a[15:0] * b : a / b;
      r = i[0] ? 16'h0000 : 16'(a % b);
      rc(3'h1, q[15:0]);
      rc(3'h2, q[31:16]);
      rc(3'h0, r);
    end
    u_cpu.wr(3'h0, 2'b11, ~r);
    rc(3'h0, r);
    u_cpu.wr(3'h4, 2'b01, 16'h0080);
    u_cpu.wr(3'h4, 2'b01, 16'h0000);
    n = 0;
    repeat (40)
    begin
      u_cpu.rd(3'h4, d);
      n += (muldiv_done_irq === 1'b1);
    end
    check(n[15:0], 16'h0000);
    rc(3'h4, 16'h0000);
    end_of_test;
  end
endmodule // tb_mul_div_unit
